// >>> hw/omc_pkg.sv
// Package: constants and types for the output macrocell array
package omc_pkg;

  // Array geometry
  localparam int NUM_MC   = 8;
  localparam int NUM_PT   = 8;
  // Product term that doubles as output enable on I/O macrocells
  localparam int OE_PT    = 0;
  // Outermost and innermost macrocell positions
  localparam int OUTER_LO = 0;
  localparam int OUTER_HI = 7;
  localparam int INNER_LO = 3;
  localparam int INNER_HI = 4;
  // Synchroniser depth for pin inputs
  localparam int SYNC_DEPTH = 2;

  // Reset values
  localparam logic [7:0] RST_PIN_DATA = 8'h00;
  localparam logic [7:0] RST_PIN_OE_N = 8'hFF;
  localparam logic [7:0] RST_REG_Q    = 8'h00;
  localparam logic [7:0] RST_FB       = 8'h00;

  // Global mode, one-hot
  typedef enum logic [3:0] {
    OMC_MODE_REG     = 4'h1,
    OMC_MODE_COMPLEX = 4'h2,
    OMC_MODE_SIMPLE  = 4'h4,
    OMC_MODE_NONE    = 4'h8
  } omc_mode_e;

  // Eight product terms of one macrocell
  typedef logic [NUM_PT-1:0] omc_pterm_t;

  // Two global architecture bits
  typedef struct packed {
    logic global_register_select;
    logic global_arch_select;
  } omc_global_s;

  // Sixteen per-macrocell architecture bits
  typedef struct packed {
    logic [NUM_MC-1:0] polarity;
    logic [NUM_MC-1:0] macrocell_io_config;
  } omc_mc_cfg_s;

endpackage

// >>> hw/omc_output_macrocell_array.sv
// Module: configurable array of eight output macrocells
`timescale 1ns/1ps
`default_nettype none

module omc_output_macrocell_array (
  // System clock and reset
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  // Architecture bits and product terms, same clock
  input  wire omc_pkg::omc_global_s                 global_cfg_in,
  input  wire omc_pkg::omc_mc_cfg_s                 mc_cfg_in,
  input  wire omc_pkg::omc_pterm_t [omc_pkg::NUM_MC-1:0] pterm_in,
  // Board pins, asynchronous to clk_in
  input  wire logic                                 clk_pin_in,
  input  wire logic                                 oe_n_pin_in,
  input  wire logic [omc_pkg::NUM_MC-1:0]           mc_pin_in,
  // Pin drive, enables, array paths and mode
  output logic [omc_pkg::NUM_MC-1:0]                mc_pin_out,
  output logic [omc_pkg::NUM_MC-1:0]                mc_pin_oe_n_out,
  output logic [omc_pkg::NUM_MC-1:0]                feedback_out,
  output logic [1:0]                                dedicated_in_out,
  output omc_pkg::omc_mode_e                        mode_out
);

  // Sum of the product terms; with an enable term that term is left out
  function automatic logic sum_terms(input omc_pkg::omc_pterm_t pt,
                                     input logic                use_oe);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < omc_pkg::NUM_PT; k++) begin
      if (!(use_oe && k == omc_pkg::OE_PT)) begin
        acc = acc | pt[k];
      end
    end
    return acc;
  endfunction

  // Polarity stage: 0 inverts (active low), 1 passes (active high)
  function automatic logic apply_pol(input logic v, input logic pol);
    return pol ? v : ~v;
  endfunction

  // Synchronised copies of the board pins
  logic [omc_pkg::SYNC_DEPTH-1:0] clk_sync;
  logic [omc_pkg::SYNC_DEPTH-1:0] oe_sync;
  logic [omc_pkg::NUM_MC-1:0]     pin_meta;
  logic [omc_pkg::NUM_MC-1:0]     pin_sync;

  // Shared clock edge detect
  logic                           clk_prev;
  logic                           clk_rise;

  // Decoded mode and registered cells
  omc_pkg::omc_mode_e             mode;
  logic [omc_pkg::NUM_MC-1:0]     reg_q;

  // Next values of the flopped outputs
  logic [omc_pkg::NUM_MC-1:0]     next_pin;
  logic [omc_pkg::NUM_MC-1:0]     next_oe_n;
  logic [omc_pkg::NUM_MC-1:0]     next_fb;
  logic [1:0]                     next_ded;

  // Mode decode from the two global bits
  always_comb begin
    case ({global_cfg_in.global_register_select,
           global_cfg_in.global_arch_select})
      2'h1:    mode = omc_pkg::OMC_MODE_REG;
      2'h3:    mode = omc_pkg::OMC_MODE_COMPLEX;
      2'h2:    mode = omc_pkg::OMC_MODE_SIMPLE;
      default: mode = omc_pkg::OMC_MODE_NONE;
    endcase
  end

  // Shared clock pin synchroniser; idles low so reset makes no false edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sync <= '0;
    end else begin
      clk_sync <= {clk_sync[0], clk_pin_in};
    end
  end

  // Shared enable pin synchroniser; resets to the disabled level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_sync <= '1;
    end else begin
      oe_sync <= {oe_sync[0], oe_n_pin_in};
    end
  end

  // Macrocell pin synchroniser; only the second flop is read elsewhere
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= mc_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Edge detect on the synchronised shared clock, never on the first flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_sync[1];
    end
  end

  assign clk_rise = clk_sync[1] & ~clk_prev;

  // Per-macrocell register and pin/feedback decode
  for (genvar i = 0; i < omc_pkg::NUM_MC; i++) begin : g_mc
    localparam bit IS_OUTER = (i == omc_pkg::OUTER_LO) ||
                              (i == omc_pkg::OUTER_HI);
    localparam bit IS_INNER = (i == omc_pkg::INNER_LO) ||
                              (i == omc_pkg::INNER_HI);
    // Simple-mode path of cell i carries the pin of its outward neighbour
    localparam int NBR = (i < omc_pkg::INNER_HI) ? i - 1 : i + 1;
    logic nbr_pin;

    if (IS_OUTER) begin : g_outer
      assign nbr_pin = 1'b0;
    end else begin : g_inner
      assign nbr_pin = pin_sync[NBR];
    end

    // Sums of all eight terms and of the seven beside the enable term
    logic sum_all;
    logic sum_io;
    logic load_en;
    assign sum_all = sum_terms(pterm_in[i], 1'b0);
    assign sum_io  = sum_terms(pterm_in[i], 1'b1);

    // Load strobe: shared clock rise on a registered cell only
    assign load_en = clk_rise && mode == omc_pkg::OMC_MODE_REG &&
                     !mc_cfg_in.macrocell_io_config[i];

    // Registered cell loads on the shared clock rise only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        reg_q[i] <= omc_pkg::RST_REG_Q[i];
      end else if (load_en) begin
        reg_q[i] <= apply_pol(sum_all, mc_cfg_in.polarity[i]);
      end
    end

    // Pin drive and enable of this cell
    always_comb begin
      logic io;
      logic pol;
      io           = mc_cfg_in.macrocell_io_config[i];
      pol          = mc_cfg_in.polarity[i];
      next_pin[i]  = 1'b0;
      next_oe_n[i] = 1'b1;
      case (mode)
        omc_pkg::OMC_MODE_REG: begin
          if (!io) begin
            // Shared active-low enable; high floats the output
            next_pin[i]  = reg_q[i];
            next_oe_n[i] = oe_sync[1];
          end else begin
            // I/O cell: term 0 is the enable, seven terms form the sum
            next_pin[i]  = apply_pol(sum_io, pol);
            next_oe_n[i] = ~pterm_in[i][omc_pkg::OE_PT];
          end
        end
        omc_pkg::OMC_MODE_COMPLEX: begin
          // Every cell is output or I/O with term-controlled enable
          next_pin[i]  = apply_pol(sum_io, pol);
          next_oe_n[i] = ~pterm_in[i][omc_pkg::OE_PT];
        end
        omc_pkg::OMC_MODE_SIMPLE: begin
          // Inner cells always drive; others drive unless dedicated input
          if (IS_INNER || !io) begin
            next_pin[i]  = apply_pol(sum_all, pol);
            next_oe_n[i] = 1'b0;
          end
        end
        default: begin
          // Undefined global code: all pins float
          next_oe_n[i] = 1'b1;
        end
      endcase
    end

    // Path of this cell into the array; outer paths may carry the pins
    always_comb begin
      next_fb[i] = 1'b0;
      case (mode)
        omc_pkg::OMC_MODE_REG: begin
          // Registered cells return q, I/O cells their own pin
          if (!mc_cfg_in.macrocell_io_config[i]) begin
            next_fb[i] = reg_q[i];
          end else begin
            next_fb[i] = pin_sync[i];
          end
        end
        omc_pkg::OMC_MODE_COMPLEX: begin
          if (i == omc_pkg::OUTER_HI) begin
            next_fb[i] = clk_sync[1];
          end else if (i == omc_pkg::OUTER_LO) begin
            next_fb[i] = oe_sync[1];
          end else begin
            next_fb[i] = pin_sync[i];
          end
        end
        omc_pkg::OMC_MODE_SIMPLE: begin
          // Neighbour routing leaves the inner pins with no path back
          if (i == omc_pkg::OUTER_HI) begin
            next_fb[i] = clk_sync[1];
          end else if (i == omc_pkg::OUTER_LO) begin
            next_fb[i] = oe_sync[1];
          end else begin
            next_fb[i] = nbr_pin;
          end
        end
        default: begin
          // Undefined global code: nothing reaches the array
          next_fb[i] = 1'b0;
        end
      endcase
    end
  end

  // Clock and enable pins are array inputs only in complex and simple modes
  always_comb begin
    if (mode == omc_pkg::OMC_MODE_COMPLEX ||
        mode == omc_pkg::OMC_MODE_SIMPLE) begin
      next_ded = {oe_sync[1], clk_sync[1]};
    end else begin
      next_ded = 2'h0;
    end
  end

  // Pin data; one cycle from decode so a mode change never glitches a pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mc_pin_out <= omc_pkg::RST_PIN_DATA;
    end else begin
      mc_pin_out <= next_pin;
    end
  end

  // Pin enables; reset floats every pin until the mode is known
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mc_pin_oe_n_out <= omc_pkg::RST_PIN_OE_N;
    end else begin
      mc_pin_oe_n_out <= next_oe_n;
    end
  end

  // Array paths of all eight cells
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      feedback_out <= omc_pkg::RST_FB;
    end else begin
      feedback_out <= next_fb;
    end
  end

  // Clock and enable pins seen as array inputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dedicated_in_out <= 2'h0;
    end else begin
      dedicated_in_out <= next_ded;
    end
  end

  // Decoded mode, in step with the pins it explains
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out <= omc_pkg::OMC_MODE_NONE;
    end else begin
      mode_out <= mode;
    end
  end

endmodule

`default_nettype wire

// >>> verif/omc_array_properties.sv
// Checker: port-level properties of the macrocell array
`timescale 1ns/1ps
`default_nettype none
module omc_array_properties (
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire omc_pkg::omc_global_s      global_cfg_in,
  input wire omc_pkg::omc_mc_cfg_s      mc_cfg_in,
  input wire omc_pkg::omc_pterm_t [7:0] pterm_in,
  input wire logic                      clk_pin_in,
  input wire logic                      oe_n_pin_in,
  input wire logic [7:0]                mc_pin_out,
  input wire logic [7:0]                mc_pin_oe_n_out,
  input wire logic [7:0]                feedback_out,
  input wire logic [1:0]                dedicated_in_out,
  input wire omc_pkg::omc_mode_e        mode_out
);
  localparam omc_pkg::omc_mode_e MR = omc_pkg::OMC_MODE_REG;
  localparam omc_pkg::omc_mode_e MC = omc_pkg::OMC_MODE_COMPLEX;
  localparam omc_pkg::omc_mode_e MS = omc_pkg::OMC_MODE_SIMPLE;
  localparam omc_pkg::omc_mode_e MN = omc_pkg::OMC_MODE_NONE;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shared clock rise on a registered cell, then a quiet spell
  sequence s_rise;
    $rose(clk_pin_in) && mode_out == MR && !mc_cfg_in.macrocell_io_config[0];
  endsequence
  sequence s_hold;
    ($stable(mc_cfg_in) && $stable(pterm_in[0]) && mode_out == MR)[*4];
  endsequence
  a_mode_decode: assert property (1 |=> mode_out ==
    ($past(global_cfg_in) == 2'h1 ? MR : $past(global_cfg_in) == 2'h3 ? MC
    : $past(global_cfg_in) == 2'h2 ? MS : MN)) else $error("bad mode");
  a_undef_floats: assert property (mode_out == MN |->
    mc_pin_oe_n_out == 8'hFF && feedback_out == 8'h00)
    else $error("undefined mode drives");
  a_reg_no_ded: assert property (mode_out == MR |->
    dedicated_in_out == 2'h0) else $error("clock pin used as data");
  // Pins reach the outputs three edges late through the synchroniser
  a_complex_ded: assert property (mode_out == MC |->
    dedicated_in_out == {$past(oe_n_pin_in, 3), $past(clk_pin_in, 3)}
    && feedback_out[7] == $past(clk_pin_in, 3)
    && feedback_out[0] == $past(oe_n_pin_in, 3)) else $error("bad dedicated");
  a_inner_drive: assert property (mode_out == MS |->
    mc_pin_oe_n_out[4:3] == 2'h0) else $error("inner cell floats");
  a_reg_oe: assert property (mode_out == MR &&
    !$past(mc_cfg_in.macrocell_io_config[1]) |->
    mc_pin_oe_n_out[1] == $past(oe_n_pin_in, 3)) else $error("bad shared oe");
  a_io_enable: assert property (mode_out == MR &&
    $past(mc_cfg_in.macrocell_io_config[2]) |->
    mc_pin_oe_n_out[2] == !$past(pterm_in[2][0])) else $error("bad term oe");
  a_reg_load: assert property (s_rise ##1 s_hold |->
    mc_pin_out[0] == (mc_cfg_in.polarity[0] ~^ |pterm_in[0]))
    else $error("register missed load");
endmodule
bind omc_output_macrocell_array omc_array_properties CHK (.*);
`default_nettype wire

// >>> verif/omc_board.sv
// Partner: board wiring of the eight macrocell pins
`timescale 1ns/1ps
`default_nettype none
module omc_board (
  input  wire logic [7:0] pin_drv_in,
  input  wire logic [7:0] pin_oe_n_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] wire_out
);
  // Device wins, then board; the pull-up keeps a released pin high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wire_out[i] = !pin_oe_n_in[i] ? pin_drv_in[i]
        : ext_en_in[i] ? ext_val_in[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/output_macrocell_config_test.sv
// Testbench: mode table, shared clock, feedback routing
`timescale 1ns/1ps
`default_nettype none
module output_macrocell_config_test;
  typedef struct packed {
    logic [1:0] g;
    logic [7:0] io, pol, pt;
    logic [3:0] md;
    logic [7:0] oe, dat;
  } omc_row_s;
  // Config, terms, then expected mode, enables and driven data
  localparam omc_row_s ROWS [8] = '{
    '{2'h2, 8'h00, 8'hFF, 8'h01, 4'h4, 8'h00, 8'hFF},
    '{2'h2, 8'hFF, 8'h0F, 8'h00, 4'h4, 8'hE7, 8'h10},
    '{2'h3, 8'hFF, 8'hFF, 8'h01, 4'h2, 8'h00, 8'h00},
    '{2'h3, 8'hFF, 8'h00, 8'hFE, 4'h2, 8'hFF, 8'h00},
    '{2'h3, 8'hFF, 8'h55, 8'hFF, 4'h2, 8'h00, 8'h55},
    '{2'h1, 8'hFF, 8'hAA, 8'hFF, 4'h1, 8'h00, 8'hAA},
    '{2'h1, 8'hFF, 8'h00, 8'h01, 4'h1, 8'h00, 8'hFF},
    '{2'h0, 8'h00, 8'hFF, 8'hFF, 4'h8, 8'hFF, 8'h00}
  };
  logic                      clk_in = 1'b0, rst_n_in = 1'b0;
  logic                      clk_pin = 1'b0, oe_pin = 1'b1;
  omc_pkg::omc_global_s      g;
  omc_pkg::omc_mc_cfg_s      mc;
  omc_pkg::omc_pterm_t [7:0] pt;
  logic [7:0]                en = 8'h00, val = 8'h00, wire_lv, dat, oe_n, fb;
  logic [1:0]                ded;
  omc_pkg::omc_mode_e        md;
  int                        miscompares = 0, compares = 0;
  omc_output_macrocell_array DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .global_cfg_in(g), .mc_cfg_in(mc), .pterm_in(pt), .clk_pin_in(clk_pin),
    .oe_n_pin_in(oe_pin), .mc_pin_in(wire_lv), .mc_pin_out(dat),
    .mc_pin_oe_n_out(oe_n), .feedback_out(fb), .dedicated_in_out(ded),
    .mode_out(md));
  omc_board BOARD (.pin_drv_in(dat), .pin_oe_n_in(oe_n), .ext_en_in(en),
    .ext_val_in(val), .wire_out(wire_lv));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Inputs move on the falling edge, away from the sampling edge
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic cfg(input omc_row_s r);
    g = r.g;
    mc = {r.pol, r.io};
    pt = {8{r.pt}};
  endtask
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #5000;
    miscompares++;
    conclude();
  end
  initial begin
    cfg(ROWS[7]);
    wait_n(20);
    check(oe_n, 8'hFF);
    check(dat, 8'h00);
    rst_n_in = 1;
    foreach (ROWS[i]) begin
      cfg(ROWS[i]);
      wait_n(2);
      check({4'h0, md}, {4'h0, ROWS[i].md});
      check(oe_n, ROWS[i].oe);
      check(dat & ~oe_n, ROWS[i].dat);
    end
    // Registered cells load only on a shared clock rise
    cfg('{2'h1, 8'h00, 8'hFF, 8'h01, 4'h1, 8'h00, 8'h00});
    oe_pin = 0;
    wait_n(4);
    clk_pin = 1;
    wait_n(6);
    check(dat, 8'hFF);
    check(oe_n, 8'h00);
    check(fb, 8'hFF);
    check({6'h0, ded}, 8'h00);
    pt = '0;
    wait_n(6);
    check(dat, 8'hFF);
    clk_pin = 0;
    wait_n(3);
    clk_pin = 1;
    wait_n(6);
    check(dat, 8'h00);
    oe_pin = 1;
    wait_n(4);
    check(oe_n, 8'hFF);
    // Complex mode: pins become data on the outer paths
    cfg(ROWS[2]);
    clk_pin = 0;
    wait_n(5);
    check({6'h0, ded}, 8'h02);
    check({6'h0, fb[7], fb[0]}, 8'h01);
    // Simple mode: neighbour feedback, inner pins never fed back
    cfg(ROWS[1]);
    en = 8'hE7;
    val = 8'h41;
    wait_n(5);
    check({2'h0, fb[6:1]}, 8'h11);
    // Mid-run reset floats every pin, then simple routing returns
    rst_n_in = 1'b0;
    wait_n(2);
    check(oe_n, 8'hFF);
    check({4'h0, md}, 8'h08);
    rst_n_in = 1'b1;
    wait_n(5);
    check({2'h0, fb[6:1]}, 8'h11);
    conclude();
  end
endmodule
`default_nettype wire
